//--- shared/cmd_core_pkg.sv
// Constants shared by the general-command core: map, opcodes, codes
package cmd_core_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CMD        = 8'h00;
  localparam logic [7:0] OFS_PASS       = 8'h04;
  localparam logic [7:0] OFS_STATUS     = 8'h08;
  localparam logic [7:0] OFS_REPLY_HDR  = 8'h0C;
  localparam logic [7:0] OFS_REPLY_DATA = 8'h10;
  localparam logic [7:0] OFS_TIMESTAMP  = 8'h14;
  localparam logic [7:0] OFS_MEAS_CNT   = 8'h18;
  // Command word fields
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_ARG_LSB = 8;
  localparam int CMD_SET_BIT = 16;
  // Opcodes
  localparam logic [7:0] OP_HELP    = 8'h01;
  localparam logic [7:0] OP_INFO    = 8'h02;
  localparam logic [7:0] OP_ECHO    = 8'h03;
  localparam logic [7:0] OP_DUMP    = 8'h04;
  localparam logic [7:0] OP_SYNC    = 8'h05;
  localparam logic [7:0] OP_TERM    = 8'h06;
  localparam logic [7:0] OP_RESTART = 8'h07;
  localparam logic [7:0] OP_CLEAR   = 8'h08;
  localparam logic [7:0] OP_RAISE   = 8'h09;
  localparam logic [7:0] OP_DROP    = 8'h0A;
  localparam logic [7:0] OP_STARTUP = 8'h0B;
  localparam logic [7:0] OP_EDGE    = 8'h0C;
  // Reply status codes
  localparam logic [7:0] ST_OK      = 8'h00;
  localparam logic [7:0] ST_UNKNOWN = 8'h01;
  localparam logic [7:0] ST_BAD_ARG = 8'h02;
  localparam logic [7:0] ST_ACCESS  = 8'h03;
  // Help answers: general text id, per-command tag in the upper half
  localparam logic [31:0] HELP_GENERAL = 32'h0000_0000;
  localparam logic [15:0] HELP_TAG     = 16'h0001;
  // Number of items for the info query and the parameter dump
  localparam logic [7:0] INFO_ITEMS = 8'h0A;
  localparam logic [7:0] DUMP_ITEMS = 8'h07;
  // Counter-clear argument bits
  localparam int CLR_TS_BIT = 0;
  localparam int CLR_MC_BIT = 1;
  // Status register bit positions
  localparam int STS_LEVEL   = 0;
  localparam int STS_STARTUP = 1;
  localparam int STS_ECHO    = 2;
  localparam int STS_TERM    = 3;
  localparam int STS_EDGE    = 4;
  localparam int STS_ROLE    = 5;
  localparam int STS_CLR_TS  = 7;
  localparam int STS_CLR_MC  = 8;
  localparam int STS_READY   = 9;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Synchronisation role
  typedef enum logic [1:0] {
    ROLE_NONE,
    ROLE_MASTER,
    ROLE_FOLLOW_DIFF,
    ROLE_FOLLOW_TRIG
  } sync_role_e;
endpackage

//--- core/cmd_core.sv
// General-command interpreter core with AXI4-Lite register access
`timescale 1ns/1ps

// Function
// - Help: general text or per-command help
// - Info query reports ten identity items
// - Echo on: reply carries command name
// - Echo off: reply omits command name
// - Dump returns every setting with value
// - Sync role: none, master, two followers
// - Diff follower never drives sync line
// - Trigger follower syncs from trigger input
// - Trigger input also gives trigger edges
// - Termination setting switches line resistor
// - Counter clear waits for trigger edge
// - Clear only the named counters
// - Matching password raises to privileged
// - Basic level: reads ok, set forms rejected; clear and restart run
// - Privileged level: reads and writes
// - Drop command returns to basic level
// - Startup setting picks level after start
module cmd_core
  import cmd_core_pkg::*;
#(
  parameter logic [31:0] PASSWORD      = 32'h0000_0000,
  parameter int unsigned SYNC_PERIOD   = 250,
  parameter logic        STARTUP_PRIV  = 1'b0,
  parameter logic [31:0] MODEL_ID      = 32'h0000_0001, // Arbitrary
  parameter logic [31:0] SERIAL_NO     = 32'h0000_0002, // Arbitrary
  parameter logic [31:0] OPTION_NO     = 32'h0000_0003, // Arbitrary
  parameter logic [31:0] ARTICLE_NO    = 32'h0000_0004, // Arbitrary
  parameter logic [47:0] NET_ADDR      = 48'h0200_0000_0001, // Arbitrary
  parameter logic [31:0] SW_VERSION    = 32'h0000_0005, // Arbitrary
  parameter logic [31:0] HW_REVISION   = 32'h0000_0006, // Arbitrary
  parameter logic [31:0] BOOT_VERSION  = 32'h0000_0007, // Arbitrary
  parameter logic [31:0] BUILD_ID      = 32'h0000_0008  // Arbitrary
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  output logic             s_axi_rready_unused_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        sync_in_i,
  output logic             sync_out_o,
  output logic             sync_oe_b_o,
  input  wire logic        trigger_input_pin_i,
  output logic             termination_en_o,
  output logic             sync_pulse_o,
  output logic             trigger_edge_o
);

  localparam logic [15:0] SYNC_LAST = 16'(SYNC_PERIOD - 1);

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return m;
  endfunction

  // Opcodes the interpreter knows
  function automatic logic known_op(input logic [7:0] op);
    return (op >= OP_HELP) && (op <= OP_EDGE);
  endfunction

  // Opcodes whose set form changes a stored setting
  function automatic logic has_set(input logic [7:0] op);
    return op == OP_ECHO || op == OP_SYNC || op == OP_TERM ||
           op == OP_STARTUP || op == OP_EDGE;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State
  logic        aw_pend_r, aw_pend_nxt, w_pend_r, w_pend_nxt;
  logic [7:0]  awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] pass_r, pass_nxt;
  logic        priv_r, priv_nxt, startup_r, startup_nxt;
  logic        echo_r, echo_nxt, term_r, term_nxt, edge_r, edge_nxt;
  sync_role_e  role_r, role_nxt;
  logic        clr_ts_r, clr_ts_nxt, clr_mc_r, clr_mc_nxt;
  logic        ready_r, ready_nxt;
  logic [15:0] hdr_r, hdr_nxt;
  logic [31:0] reply_r, reply_nxt;
  logic [31:0] ts_r, ts_nxt, mc_r, mc_nxt;
  logic [15:0] div_r, div_nxt;
  logic        spulse_r, spulse_nxt;
  logic [1:0]  sync_sy_r, trig_sy_r;
  logic        sync_d_r, trig_d_r, startup_seen_r;

  // Decoded command of the write in flight
  logic        wr_go, exec, set_f, sync_evt, trig_edge, sync_rise;
  logic [31:0] cmd_w;
  logic [7:0]  op, arg;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage feeds edge logic
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_sy_r <= 2'b00;
      trig_sy_r <= 2'b00;
      sync_d_r  <= 1'b0;
      trig_d_r  <= 1'b0;
    end else begin
      sync_sy_r <= {sync_sy_r[0], sync_in_i};
      trig_sy_r <= {trig_sy_r[0], trigger_input_pin_i};
      sync_d_r  <= sync_sy_r[1];
      trig_d_r  <= trig_sy_r[1];
    end
  end

  assign trig_edge = edge_r ? (trig_d_r & ~trig_sy_r[1])
                            : (trig_sy_r[1] & ~trig_d_r);
  assign sync_rise = sync_sy_r[1] & ~sync_d_r;
  always_comb begin
    unique case (role_r)
      ROLE_NONE:        sync_evt = 1'b0;
      ROLE_MASTER:      sync_evt = (div_r == SYNC_LAST);
      ROLE_FOLLOW_DIFF: sync_evt = sync_rise;
      ROLE_FOLLOW_TRIG: sync_evt = trig_sy_r[1] & ~trig_d_r;
    endcase
  end

  assign wr_go = aw_pend_r & w_pend_r & ~bvalid_r;
  assign cmd_w = wdata_r & {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                            {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign op    = cmd_w[CMD_OP_LSB +: 8];
  assign arg   = cmd_w[CMD_ARG_LSB +: 8];
  assign set_f = cmd_w[CMD_SET_BIT];
  assign exec  = wr_go && (awaddr_r == OFS_CMD);

  ////////////////////////////////////////////////////////////////////////
  // Next-state: bus slave, command interpreter, counters
  always_comb begin
    aw_pend_nxt = aw_pend_r;   awaddr_nxt = awaddr_r;
    w_pend_nxt  = w_pend_r;    wdata_nxt  = wdata_r;
    wstrb_nxt   = wstrb_r;     bvalid_nxt = bvalid_r;
    bresp_nxt   = bresp_r;     rvalid_nxt = rvalid_r;
    rresp_nxt   = rresp_r;     rdata_nxt  = rdata_r;
    pass_nxt    = pass_r;      priv_nxt   = priv_r;
    startup_nxt = startup_r;   echo_nxt   = echo_r;
    term_nxt    = term_r;      edge_nxt   = edge_r;
    role_nxt    = role_r;      clr_ts_nxt = clr_ts_r;
    clr_mc_nxt  = clr_mc_r;    ready_nxt  = ready_r;
    hdr_nxt     = hdr_r;       reply_nxt  = reply_r;
    ts_nxt      = ts_r + 32'h0000_0001;
    mc_nxt      = mc_r + {31'h0000_0000, sync_evt};
    spulse_nxt  = sync_evt;
    div_nxt     = (role_r != ROLE_MASTER || div_r == SYNC_LAST)
                  ? 16'h0000 : div_r + 16'h0001;

    // Write address and data are taken in either order
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_pend_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_pend_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata_i;
      wstrb_nxt  = s_axi_wstrb_i;
    end
    if (bvalid_r && s_axi_bready_i) begin
      bvalid_nxt = 1'b0;
    end
    if (rvalid_r && s_axi_rready_i) begin
      rvalid_nxt = 1'b0;
    end

    // Read: answer registered on the same edge that takes the address
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      unique case (s_axi_araddr_i)
        OFS_CMD:        rdata_nxt = 32'h0000_0000;
        OFS_PASS:       rdata_nxt = 32'h0000_0000; // Never reveal it
        OFS_STATUS:     rdata_nxt = {22'h00_0000, ready_r, clr_mc_r,
                                     clr_ts_r, role_r, edge_r, term_r,
                                     echo_r, startup_r, priv_r};
        OFS_REPLY_HDR:  rdata_nxt = {16'h0000, hdr_r};
        OFS_REPLY_DATA: begin
          rdata_nxt = reply_r;
          ready_nxt = 1'b0; // Reading the answer consumes it
        end
        OFS_TIMESTAMP:  rdata_nxt = ts_r;
        OFS_MEAS_CNT:   rdata_nxt = mc_r;
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end

    // clear waits for the trigger edge
    if (trig_edge) begin
      if (clr_ts_r) begin
        ts_nxt     = 32'h0000_0000;
        clr_ts_nxt = 1'b0;
      end
      if (clr_mc_r) begin
        mc_nxt     = 32'h0000_0000;
        clr_mc_nxt = 1'b0;
      end
    end

    // Register write: one edge after both halves are held
    if (wr_go) begin
      aw_pend_nxt = 1'b0;
      w_pend_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = RESP_OKAY;
      if (awaddr_r == OFS_PASS) begin
        pass_nxt = merge(pass_r, wdata_r, wstrb_r);
      end else if (awaddr_r != OFS_CMD) begin
        bresp_nxt = RESP_SLVERR;
      end
    end

    if (exec) begin
      // A new answer wins over a read that consumes the old one
      ready_nxt = 1'b1;
      hdr_nxt   = {echo_r ? op : 8'h00, ST_OK};
      reply_nxt = 32'h0000_0000;
      if (!known_op(op)) begin
        hdr_nxt[7:0] = ST_UNKNOWN;
      end else if (set_f && has_set(op) && !priv_r) begin
        hdr_nxt[7:0] = ST_ACCESS;
      end else begin
        unique case (op)
          OP_HELP: begin
            if (arg == 8'h00) begin
              reply_nxt = HELP_GENERAL;
            end else if (known_op(arg)) begin
              reply_nxt = {HELP_TAG, 8'h00, arg};
            end else begin
              hdr_nxt[7:0] = ST_BAD_ARG;
            end
          end
          OP_INFO: begin
            unique case (arg)
              8'h00:   reply_nxt = MODEL_ID;
              8'h01:   reply_nxt = SERIAL_NO;
              8'h02:   reply_nxt = OPTION_NO;
              8'h03:   reply_nxt = ARTICLE_NO;
              8'h04:   reply_nxt = NET_ADDR[31:0];
              8'h05:   reply_nxt = {16'h0000, NET_ADDR[47:32]};
              8'h06:   reply_nxt = SW_VERSION;
              8'h07:   reply_nxt = HW_REVISION;
              8'h08:   reply_nxt = BOOT_VERSION;
              8'h09:   reply_nxt = BUILD_ID;
              default: hdr_nxt[7:0] = ST_BAD_ARG;
            endcase
          end
          OP_DUMP: begin
            unique case (arg)
              8'h00:   reply_nxt = {31'h0000_0000, echo_r};
              8'h01:   reply_nxt = {30'h0000_0000, role_r};
              8'h02:   reply_nxt = {31'h0000_0000, term_r};
              8'h03:   reply_nxt = {31'h0000_0000, priv_r};
              8'h04:   reply_nxt = {31'h0000_0000, startup_r};
              8'h05:   reply_nxt = {31'h0000_0000, edge_r};
              8'h06:   reply_nxt = {30'h0000_0000, clr_mc_r, clr_ts_r};
              default: hdr_nxt[7:0] = ST_BAD_ARG;
            endcase
          end
          OP_ECHO: begin
            if (set_f) echo_nxt = arg[0];
            reply_nxt = {31'h0000_0000, set_f ? arg[0] : echo_r};
          end
          OP_SYNC: begin
            if (set_f) role_nxt = sync_role_e'(arg[1:0]);
            reply_nxt = {30'h0000_0000, set_f ? arg[1:0] : role_r};
          end
          OP_TERM: begin
            if (set_f) term_nxt = arg[0];
            reply_nxt = {31'h0000_0000, set_f ? arg[0] : term_r};
          end
          OP_STARTUP: begin
            if (set_f) startup_nxt = arg[0];
            reply_nxt = {31'h0000_0000, set_f ? arg[0] : startup_r};
          end
          OP_EDGE: begin
            if (set_f) edge_nxt = arg[0];
            reply_nxt = {31'h0000_0000, set_f ? arg[0] : edge_r};
          end
          OP_CLEAR: begin
            if (arg[CLR_TS_BIT]) clr_ts_nxt = 1'b1;
            if (arg[CLR_MC_BIT]) clr_mc_nxt = 1'b1;
          end
          OP_RAISE: begin
            if (pass_r == PASSWORD) begin
              priv_nxt = 1'b1;
            end else begin
              hdr_nxt[7:0] = ST_BAD_ARG;
            end
          end
          OP_DROP: priv_nxt = 1'b0;
          OP_RESTART: begin
            priv_nxt   = startup_r;
            echo_nxt   = 1'b1;
            term_nxt   = 1'b0;
            edge_nxt   = 1'b0;
            role_nxt   = ROLE_NONE;
            clr_ts_nxt = 1'b0;
            clr_mc_nxt = 1'b0;
            ts_nxt     = 32'h0000_0000;
            mc_nxt     = 32'h0000_0000;
            div_nxt    = 16'h0000;
          end
          default: hdr_nxt[7:0] = ST_UNKNOWN;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers; the startup level is loaded once after reset release
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_pend_r <= 1'b0;  awaddr_r <= 8'h00;
      w_pend_r  <= 1'b0;  wdata_r  <= 32'h0000_0000;
      wstrb_r   <= 4'h0;  bvalid_r <= 1'b0;
      bresp_r   <= RESP_OKAY; rvalid_r <= 1'b0;
      rresp_r   <= RESP_OKAY; rdata_r  <= 32'h0000_0000;
      pass_r    <= 32'h0000_0000;
      priv_r    <= 1'b0;  startup_r <= 1'b0;
      echo_r    <= 1'b1;  term_r    <= 1'b0;
      edge_r    <= 1'b0;  role_r    <= ROLE_NONE;
      clr_ts_r  <= 1'b0;  clr_mc_r  <= 1'b0;
      ready_r   <= 1'b0;  hdr_r     <= 16'h0000;
      reply_r   <= 32'h0000_0000;
      ts_r      <= 32'h0000_0000;
      mc_r      <= 32'h0000_0000;
      div_r     <= 16'h0000;
      spulse_r  <= 1'b0;
      startup_seen_r <= 1'b0;
    end else begin
      aw_pend_r <= aw_pend_nxt; awaddr_r <= awaddr_nxt;
      w_pend_r  <= w_pend_nxt;  wdata_r  <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;   bvalid_r <= bvalid_nxt;
      bresp_r   <= bresp_nxt;   rvalid_r <= rvalid_nxt;
      rresp_r   <= rresp_nxt;   rdata_r  <= rdata_nxt;
      pass_r    <= pass_nxt;    echo_r   <= echo_nxt;
      term_r    <= term_nxt;    edge_r   <= edge_nxt;
      role_r    <= role_nxt;    clr_ts_r <= clr_ts_nxt;
      clr_mc_r  <= clr_mc_nxt;  ready_r  <= ready_nxt;
      hdr_r     <= hdr_nxt;     reply_r  <= reply_nxt;
      ts_r      <= ts_nxt;      mc_r     <= mc_nxt;
      div_r     <= div_nxt;     spulse_r <= spulse_nxt;
      startup_seen_r <= 1'b1;
      if (!startup_seen_r) begin
        startup_r <= STARTUP_PRIV;
        priv_r    <= STARTUP_PRIV;
      end else begin
        startup_r <= startup_nxt;
        priv_r    <= priv_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs; ready signals combinational, valids and data from flip-flops
  assign s_axi_awready_o = ~aw_pend_r & ~bvalid_r;
  assign s_axi_wready_o  = ~w_pend_r & ~bvalid_r;
  assign s_axi_bvalid_o  = bvalid_r;
  assign s_axi_bresp_o   = bresp_r;
  assign s_axi_arready_o = ~rvalid_r;
  assign s_axi_rvalid_o  = rvalid_r;
  assign s_axi_rresp_o   = rresp_r;
  assign s_axi_rdata_o   = rdata_r;
  assign s_axi_rready_unused_o = 1'b0;
  // only the master drives the line
  assign sync_oe_b_o      = (role_r != ROLE_MASTER);
  assign sync_out_o       = spulse_r & (role_r == ROLE_MASTER);
  assign sync_pulse_o     = spulse_r;
  assign trigger_edge_o   = trig_edge;
  assign termination_en_o = term_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  line_drive_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    role_r != ROLE_MASTER |-> sync_oe_b_o && !sync_out_o)
    else $error("sync line driven outside master role");
  term_set_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    exec && op == OP_TERM && set_f && priv_r
    |=> termination_en_o == $past(arg[0]))
    else $error("termination did not follow setting");
  basic_deny_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    exec && has_set(op) && set_f && !priv_r
    |=> hdr_r[7:0] == ST_ACCESS && $stable(role_r) && $stable(echo_r)
        && $stable(term_r))
    else $error("basic level change not rejected");
  privilege_raise_cmd_ok_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    exec && op == OP_RAISE && pass_r == PASSWORD ##1 startup_seen_r
    |-> priv_r)
    else $error("privilege_raise_cmd with right password failed");
  privilege_drop_cmd_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    exec && op == OP_DROP ##1 startup_seen_r |-> !priv_r)
    else $error("privilege_drop_cmd kept privileged level");
  restart_lvl_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    exec && op == OP_RESTART
    |=> priv_r == $past(startup_r) && role_r == ROLE_NONE)
    else $error("restart did not reload settings");
  clear_wait_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    clr_ts_r && !trig_edge && !exec |=> clr_ts_r && ts_r != 32'h0000_0000)
    else $error("timestamp cleared without trigger edge");
  clear_named_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    trig_edge && clr_ts_r && !clr_mc_r && !sync_evt && !exec
    |=> ts_r == 32'h0000_0000 && mc_r == $past(mc_r))
    else $error("counter clear hit the wrong counter");
  echo_hdr_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    exec |=> hdr_r[15:8] == ($past(echo_r) ? $past(op) : 8'h00))
    else $error("reply header echo field wrong");
  unknown_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    exec && !known_op(op)
    |=> hdr_r[7:0] == ST_UNKNOWN && $stable(role_r) && $stable(priv_r))
    else $error("unknown command not reported");

endmodule

//--- testbench/sync_peer.sv
// Peer controller on the sync line and a trigger source
`timescale 1ns/1ps
module sync_peer (
  input  wire logic clk_i,
  input  wire logic go_i,
  input  wire logic dut_oe_b_i,
  input  wire logic dut_out_i,
  output logic      line_o,
  output logic      trig_o
);
  logic [2:0] cnt_r = 3'h0;
  // peer drives the line only while the core does not
  // Bit 1 rises once, two cycles after the trigger pin, so the two
  // events never land on the same cycle
  assign line_o = dut_oe_b_i ? cnt_r[1] : dut_out_i;
  // trigger pin held high for a few cycles per request
  assign trig_o = (cnt_r != 3'h0);
  always_ff @(posedge clk_i) begin
    cnt_r <= go_i ? 3'h5 : (cnt_r != 3'h0) ? cnt_r - 3'h1 : 3'h0;
  end
endmodule

//--- testbench/cmd_core_tb.sv
// Self-checking bench for the general-command core
`timescale 1ns/1ps
`define CK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value at %0t: %h not %h", $time, a, b); end end
module cmd_core_tb;
  import cmd_core_pkg::*;
  logic clk_i = 0, rst_b_i = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic awr, wr_, bv, arr, rv, s_out, oe_b, term, line, trig, go = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat, hdr, dat, v, m;
  logic [1:0] brs, rrs, r;
  int n_errors = 0, n_checks = 0;
  always #2 clk_i = ~clk_i;
  cmd_core #(.PASSWORD(32'h1234_5678), .SYNC_PERIOD(8),
    .MODEL_ID(32'h0000_00A5)) i_dut (.clk_i, .rst_b_i,
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr_), .s_axi_bresp_o(brs), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bry), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rrs),
    .s_axi_rvalid_o(rv), .s_axi_rready_unused_o(), .s_axi_rready_i(rry),
    .sync_in_i(line), .sync_out_o(s_out), .sync_oe_b_o(oe_b),
    .trigger_input_pin_i(trig), .termination_en_o(term),
    .sync_pulse_o(), .trigger_edge_o());
  sync_peer i_peer (.clk_i, .go_i(go), .dut_oe_b_i(oe_b),
    .dut_out_i(s_out), .line_o(line), .trig_o(trig));
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Write: hold each channel until taken; bready stays up between calls
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic t1, t2, t3;
    awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
    for (int k = 0; k < 60; k++) begin
      @(negedge clk_i); t1 = awv & awr; t2 = wv & wr_; t3 = bv; r = brs;
      @(posedge clk_i); if (t1) awv <= 0; if (t2) wv <= 0;
      if (t3) return;
    end
    n_errors++; complete_run();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic t1, t3;
    ara <= a; arv <= 1; rry <= 1;
    for (int k = 0; k < 60; k++) begin
      @(negedge clk_i); t1 = arv & arr; t3 = rv; d = rdat; r = rrs;
      @(posedge clk_i); if (t1) arv <= 0;
      if (t3) return;
    end
    n_errors++; complete_run();
  endtask
  task automatic cmd(input logic [7:0] op, arg, input logic s);
    wr(OFS_CMD, {15'h0, s, arg, op}); rd(OFS_REPLY_HDR, hdr);
    rd(OFS_REPLY_DATA, dat);
  endtask
  initial begin
    repeat (5) @(posedge clk_i); rst_b_i <= 1;
    repeat (2) @(posedge clk_i);
    rd(OFS_STATUS, v); `CK(v, 32'h0000_0004)
    rd(8'h1C, v); `CK(r, RESP_SLVERR)
    wr(OFS_STATUS, 32'h0000_0001); `CK(r, RESP_SLVERR)
    cmd(OP_ECHO, 8'h00, 1); `CK(hdr, {16'h0, OP_ECHO, ST_ACCESS})
    cmd(OP_ECHO, 8'h00, 0); `CK(dat, 32'h0000_0001)
    $display("basic level test done");
    wr(OFS_PASS, 32'h1234_5679); cmd(OP_RAISE, 8'h00, 0);
    `CK(hdr[7:0], ST_BAD_ARG)
    wr(OFS_PASS, 32'h1234_5678); cmd(OP_RAISE, 8'h00, 0);
    rd(OFS_STATUS, v); `CK(v, 32'h0000_0005)
    cmd(OP_TERM, 8'h01, 1); `CK(term, 1'b1)
    cmd(OP_DUMP, 8'h02, 0); `CK(dat, 32'h0000_0001)
    `CK(hdr, {16'h0, OP_DUMP, ST_OK})
    cmd(OP_SYNC, 8'h01, 1); `CK(oe_b, 1'b0)
    cmd(OP_SYNC, 8'h02, 1); `CK(oe_b, 1'b1)
    cmd(OP_ECHO, 8'h00, 1); cmd(OP_HELP, 8'h00, 0);
    `CK(hdr, {24'h0, ST_OK})
    `CK(dat, HELP_GENERAL)
    cmd(OP_HELP, OP_INFO, 0); `CK(dat, {HELP_TAG, 8'h00, OP_INFO})
    cmd(OP_INFO, 8'h00, 0); `CK(dat, 32'h0000_00A5)
    cmd(8'h3F, 8'h00, 0); `CK(hdr[7:0], ST_UNKNOWN)
    $display("privileged test done");
    cmd(OP_CLEAR, 8'h01, 0); rd(OFS_STATUS, v); `CK(v[7], 1'b1)
    rd(OFS_MEAS_CNT, m);
    go <= 1; @(posedge clk_i); go <= 0; repeat (12) @(posedge clk_i);
    rd(OFS_STATUS, v); `CK(v[7], 1'b0)
    rd(OFS_TIMESTAMP, v); `CK(v < 32'd40, 1'b1)
    // Peer gives one sync rise; the unnamed counter keeps counting
    rd(OFS_MEAS_CNT, v); `CK(v, m + 32'h0000_0001)
    cmd(OP_DROP, 8'h00, 0); rd(OFS_STATUS, v); `CK(v[0], 1'b0)
    cmd(OP_RESTART, 8'h00, 0); repeat (2) @(posedge clk_i);
    rd(OFS_STATUS, v); `CK(v, 32'h0000_0004)
    `CK(term, 1'b0)
    $display("clear and restart test done");
    complete_run();
  end
endmodule
